// file: dv/wpm_checker.sv
// Purpose: port assertions of the wake/power bank
// Assumes: single clock, active-low reset
// Notes:   bound from the testbench top
`timescale 1ns/1ps
module wpm_checker (
  input wire logic              sys_clk,
  input wire logic              arst_n,
  input wire wpm_pkg::wpm_req_s req,
  input wire logic [7:0]        receive_start_page,
  input wire logic              reload_done,
  input wire wpm_pkg::wpm_ctl_s ctl,
  input wire logic              reload_busy,
  input wire logic              reload_start,
  input wire logic              wake_pulse,
  input wire logic [7:0]        ring_last_page
);
  import wpm_pkg::*;
  logic wr_mode;
  logic wr_host;
  logic deep;
  // decoded host writes and the deep state
  assign wr_mode = req.wr && req.addr == 5'h0B;
  assign wr_host = req.wr && req.addr == 5'h1F;
  assign deep    = ctl.mode == WPM_MODE_DEEP;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  chk_ring_last_page: assert property (ring_last_page == receive_start_page - 8'h01)
    else $error("ring last page wrong");
  chk_reload_busy: assert property (reload_start |=> reload_busy)
    else $error("reload start without busy");
  chk_reload_cause: assert property (reload_start |->
    req.wr && req.addr == 5'h0C && req.wdata[0] && !reload_busy)
    else $error("reload start without trigger");
  chk_reload_end: assert property (reload_busy && reload_done |=> !reload_busy)
    else $error("busy outlives reload done");
  chk_wake_mode: assert property (wake_pulse |=> ctl.mode == WPM_MODE_NORMAL)
    else $error("mode not normal after wake");
  chk_deep_exit: assert property (deep && wr_host |-> wake_pulse)
    else $error("host wake write ignored");
  chk_deep_stay: assert property (deep && !wr_host && !wr_mode |-> !wake_pulse ##1 deep)
    else $error("deep state left without host wake");
  chk_mode_write: assert property (wr_mode && !wake_pulse |=>
    ctl.mode == $past(req.wdata[1:0]) && ctl.regulator_standby == $past(req.wdata[4]))
    else $error("power mode write not stored");
endmodule : wpm_checker

// file: dv/wpm_host_model.sv
// Purpose: host side of the register port, one access at a time
// Assumes: design samples strobes on the rising edge
// Notes:   released address and data lines show the inverse of their last value, strobes drop low
`timescale 1ns/1ps
module wpm_host_model (
  input  wire logic         sys_clk,
  input  wire logic [15:0]  rdata_q,
  output wpm_pkg::wpm_req_s req
);
  import wpm_pkg::*;
  initial req = '0;
  // drive after an edge, hold through one sampling edge, then release
  task automatic access(input logic w, input logic [4:0] a, input logic [15:0] d,
                        output logic [15:0] q);
    @(posedge sys_clk);
    #1;
    req = '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge sys_clk);
    #1;
    q = rdata_q;
    // a stale value could pass for a real one, so the bus flips
    req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask : access
endmodule : wpm_host_model

// file: dv/wpm_tb.sv
// Purpose: self-checking bench of the wake/power bank
// Assumes: host model drives the register port, bench drives events
// Notes:   mode code 11 is never written
`timescale 1ns/1ps
module testbench;
  import wpm_pkg::*;
  logic        sys_clk = 1'b0;
  logic        arst_n = 1'b0;
  wpm_req_s    req;
  wpm_evt_s    evt = '0;
  logic [7:0]  receive_start_page = 8'h60;
  logic        reload_done = 1'b0;
  logic [15:0] rdata_q;
  wpm_ctl_s    ctl;
  logic        reload_busy, reload_start, wake_pulse, data_port_wr, data_port_rd;
  logic [7:0]  ring_last_page;
  logic [15:0] n_start = '0, n_wake = '0, n_dp = '0, s0;
  int          err_total = 0;
  int          n_compared = 0;
  always #5 sys_clk = ~sys_clk;
  // pulses are combinational, so count them where they are sampled
  always @(posedge sys_clk) begin
    if (reload_start === 1'b1) n_start <= n_start + 16'h0001;
    if (wake_pulse === 1'b1) n_wake <= n_wake + 16'h0001;
    if (data_port_wr === 1'b1 || data_port_rd === 1'b1) n_dp <= n_dp + 16'h0001;
  end
  wpm_regs u_wpm_regs (.sys_clk, .arst_n, .req, .evt, .receive_start_page, .reload_done,
    .rdata_q, .ctl, .reload_busy, .reload_start, .wake_pulse, .ring_last_page,
    .data_port_wr, .data_port_rd);
  wpm_host_model u_wpm_host_model (.sys_clk, .rdata_q, .req);
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] q;
    u_wpm_host_model.access(1'b1, a, d, q);
  endtask : wr
  // byte registers are judged on their low byte only
  task automatic rdc(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] q;
    u_wpm_host_model.access(1'b0, a, 16'h0000, q);
    cmp(q & (a == 5'h10 ? 16'hFFFF : 16'h00FF), e);
  endtask : rdc
  task automatic pulse(input int k);
    @(posedge sys_clk);
    #1;
    evt[k] = 1'b1;
    @(posedge sys_clk);
    #1;
    evt = '0;
  endtask : pulse
  task automatic t_reset;
    logic [4:0]  ofs [9] = '{5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h12, 5'h11};
    logic [15:0] val [9] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'hFF, 16'hFF, 16'h0, 16'h0C, 16'h0};
    for (int i = 0; i < 9; i++) rdc(ofs[i], val[i]);
  endtask : t_reset
  task automatic t_flags;
    wr(5'h0A, 16'h0007);
    s0 = n_wake;
    for (int k = 0; k < 3; k++) pulse(k);
    rdc(5'h0A, 16'h0077);
    cmp(n_wake - s0, 16'h0000);
    wr(5'h0A, 16'h0047);
    rdc(5'h0A, 16'h0037);
    wr(5'h0B, 16'h0000);
    rdc(5'h0A, 16'h0007);
  endtask : t_flags
  // each source wakes the light state only while its enable is set
  task automatic t_light;
    for (int k = 0; k < 3; k++) begin
      for (int en = 1; en >= 0; en--) begin
        wr(5'h0A, en ? 16'h0001 << k : 16'h0000);
        wr(5'h0B, 16'h0001);
        s0 = n_wake;
        pulse(k);
        cmp(n_wake - s0, en ? 16'h0001 : 16'h0000);
        cmp({14'h0, ctl.mode}, en ? 16'h0000 : 16'h0001);
        rdc(5'h0A, (16'h0010 << k) | (en ? 16'h0001 << k : 16'h0000));
      end
    end
    wr(5'h0B, 16'h0000);
  endtask : t_light
  task automatic t_deep;
    wr(5'h0A, 16'h0007);
    wr(5'h0B, 16'h0012);
    cmp({15'h0, ctl.regulator_standby}, 16'h0001);
    s0 = n_wake;
    for (int k = 0; k < 3; k++) pulse(k);
    cmp({14'h0, ctl.mode}, 16'h0002);
    wr(5'h1F, 16'h0000);
    cmp(n_wake - s0, 16'h0001);
    cmp({14'h0, ctl.mode}, 16'h0000);
    wr(5'h0B, 16'h0000);
  endtask : t_deep
  task automatic t_reload;
    s0 = n_start;
    wr(5'h0C, 16'h0001);
    cmp({15'h0, reload_busy}, 16'h0001);
    wr(5'h0C, 16'h0001);
    cmp(n_start - s0, 16'h0001);
    @(posedge sys_clk);
    #1 reload_done = 1'b1;
    @(posedge sys_clk);
    #1 reload_done = 1'b0;
    cmp({15'h0, reload_busy}, 16'h0000);
    rdc(5'h0C, 16'h0000);
  endtask : t_reload
  task automatic t_misc;
    for (int i = 0; i < 3; i++) begin
      wr(5'h0D, 16'h0001 << i);
      cmp({13'h0, ctl.gp_timer_enable, ctl.burst_address_base_select,
           ctl.transmit_ring_enable}, 16'h0001 << i);
      rdc(5'h0D, 16'h0001 << i);
    end
    receive_start_page = 8'h41;
    #1 cmp({8'h0, ring_last_page}, 16'h0040);
    wr(5'h0E, 16'h0034);
    wr(5'h0F, 16'h0012);
    cmp(ctl.gp_timer_preload, 16'h1234);
    rdc(5'h0F, 16'h0012);
    wr(5'h12, 16'hFFFF);
    cmp({9'h0, ctl.frame_gap_segment_one}, 16'h007F);
    s0 = n_dp;
    wr(5'h10, 16'hABCD);
    rdc(5'h10, 16'hABCD);
    cmp(n_dp - s0, 16'h0002);
    wr(5'h11, 16'h00FF);
    rdc(5'h11, 16'h0000);
  endtask : t_misc
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  initial begin
    repeat (16) @(posedge sys_clk);
    #1 arst_n = 1'b1;
    repeat (2) @(posedge sys_clk);
    t_reset();
    t_flags();
    t_light();
    t_deep();
    t_reload();
    t_misc();
    complete_run();
  end
  // the tests need under two hundred cycles
  initial begin
    #100us;
    err_total++;
    complete_run();
  end
endmodule : testbench
bind wpm_regs wpm_checker u_wpm_checker (.sys_clk, .arst_n, .req, .receive_start_page,
  .reload_done, .ctl, .reload_busy, .reload_start, .wake_pulse, .ring_last_page);

// file: rtl/wpm_defs.svh
// Purpose: offsets, field positions, reset values and ring first page of the wake/power bank
// Assumes: byte-wide register port, page 3 decode done by the caller
// Notes:   definitions only
`ifndef WPM_DEFS_SVH
`define WPM_DEFS_SVH

`define WPM_OFS_WAKE_STATUS   5'h0A
`define WPM_OFS_POWER_MODE    5'h0B
`define WPM_OFS_RELOAD        5'h0C
`define WPM_OFS_MISC          5'h0D
`define WPM_OFS_TIMER_LOW     5'h0E
`define WPM_OFS_TIMER_HIGH    5'h0F
`define WPM_OFS_DATA_PORT     5'h10
`define WPM_OFS_GAP_ONE       5'h12
`define WPM_OFS_HOST_WAKE     5'h1F

`define WPM_BIT_LINK_FLAG     6
`define WPM_BIT_FRAME_FLAG    5
`define WPM_BIT_MAGIC_FLAG    4
`define WPM_BIT_LINK_EN       2
`define WPM_BIT_FRAME_EN      1
`define WPM_BIT_MAGIC_EN      0
`define WPM_BIT_REG_STANDBY   4
`define WPM_BIT_RELOAD        0
`define WPM_BIT_TIMER_EN      2
`define WPM_BIT_BURST_SEL     1
`define WPM_BIT_RING_EN       0

`define WPM_RST_TIMER_BYTE    8'hFF
`define WPM_RST_GAP_ONE       7'h0C
`define WPM_RING_FIRST_PAGE   8'h40

`endif

// file: rtl/wpm_event_flag.sv
// Purpose: one sticky wake event flag
// Assumes: event is a one-cycle pulse synchronous to sys_clk
// Notes:   a set in the same cycle as a clear wins
`timescale 1ns/1ps
module wpm_event_flag (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic set_pulse,
  input  wire logic clr_pulse,
  output logic      flag_q
);

  // set beats clear so an event at the clearing write is never lost
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else if (set_pulse) begin
      flag_q <= 1'b1;
    end else if (clr_pulse) begin
      flag_q <= 1'b0;
    end
  end

endmodule : wpm_event_flag

// file: rtl/wpm_pkg.sv
// Purpose: types shared by the wake/power register bank
// Assumes: nothing beyond the header
// Notes:   mode codes follow the two-bit power mode field
package wpm_pkg;

  typedef enum logic [1:0] {
    WPM_MODE_NORMAL = 2'b00,
    WPM_MODE_LIGHT  = 2'b01,
    WPM_MODE_DEEP   = 2'b10,
    WPM_MODE_RSVD   = 2'b11
  } wpm_mode_e;

  // host register access, one byte (data port carries 16 bits)
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } wpm_req_s;

  // wake events detected elsewhere in the controller, one-cycle pulses
  typedef struct packed {
    logic link_change;
    logic wake_frame;
    logic magic_frame;
  } wpm_evt_s;

  // control levels handed to the rest of the controller
  typedef struct packed {
    wpm_mode_e   mode;
    logic        regulator_standby;
    logic        gp_timer_enable;
    logic        burst_address_base_select;
    logic        transmit_ring_enable;
    logic [15:0] gp_timer_preload;
    logic [6:0]  frame_gap_segment_one;
  } wpm_ctl_s;

endpackage : wpm_pkg

// file: rtl/wpm_regs.sv
// Purpose: wake, power management and miscellaneous control register bank
// Assumes: host strobes are synchronous and one cycle wide; page select done outside
// Notes:   data port storage only, the buffer transfer engine lives elsewhere
`timescale 1ns/1ps
`include "wpm_defs.svh"
module wpm_regs (
  input  wire logic             sys_clk,
  input  wire logic             arst_n,
  input  wire wpm_pkg::wpm_req_s req,
  input  wire wpm_pkg::wpm_evt_s evt,
  input  wire logic [7:0]       receive_start_page,
  input  wire logic             reload_done,
  output logic [15:0]           rdata_q,
  output wpm_pkg::wpm_ctl_s     ctl,
  output logic                  reload_busy,
  output logic                  reload_start,
  output logic                  wake_pulse,
  output logic [7:0]            ring_last_page,
  output logic                  data_port_wr,
  output logic                  data_port_rd
);
  import wpm_pkg::*;

  logic       rst_meta_q;
  logic       rst_n;
  logic       wr_status;
  logic       wr_mode;
  logic       wr_reload;
  logic       wr_misc;
  logic       wr_tlow;
  logic       wr_thigh;
  logic       wr_gap;
  logic       wr_hostwake;
  logic       link_flag_q;
  logic       frame_flag_q;
  logic       magic_flag_q;
  logic       link_en_q;
  logic       frame_en_q;
  logic       magic_en_q;
  logic       standby_q;
  wpm_mode_e  mode_q;
  logic       reload_q;
  logic       timer_en_q;
  logic       burst_sel_q;
  logic       ring_en_q;
  logic [7:0] timer_low_q;
  logic [7:0] timer_high_q;
  logic [15:0] data_port_q;
  logic [6:0] gap_one_q;
  logic       light_wake;
  logic       deep_wake;
  logic [7:0] status_rd;
  logic [7:0] mode_rd;
  logic [7:0] misc_rd;

  // reset released through two flops so every flop leaves reset together
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // write decode
  always_comb begin
    wr_status   = 1'b0;
    wr_mode     = 1'b0;
    wr_reload   = 1'b0;
    wr_misc     = 1'b0;
    wr_tlow     = 1'b0;
    wr_thigh    = 1'b0;
    data_port_wr = 1'b0;
    wr_gap      = 1'b0;
    wr_hostwake = 1'b0;
    if (req.wr) begin
      if (req.addr == `WPM_OFS_WAKE_STATUS) begin
        wr_status = 1'b1;
      end else if (req.addr == `WPM_OFS_POWER_MODE) begin
        wr_mode = 1'b1;
      end else if (req.addr == `WPM_OFS_RELOAD) begin
        wr_reload = 1'b1;
      end else if (req.addr == `WPM_OFS_MISC) begin
        wr_misc = 1'b1;
      end else if (req.addr == `WPM_OFS_TIMER_LOW) begin
        wr_tlow = 1'b1;
      end else if (req.addr == `WPM_OFS_TIMER_HIGH) begin
        wr_thigh = 1'b1;
      end else if (req.addr == `WPM_OFS_DATA_PORT) begin
        data_port_wr = 1'b1;
      end else if (req.addr == `WPM_OFS_GAP_ONE) begin
        wr_gap = 1'b1;
      end else if (req.addr == `WPM_OFS_HOST_WAKE) begin
        wr_hostwake = 1'b1;
      end
    end
  end

  // data port read strobe tells the buffer engine a word was taken
  assign data_port_rd = req.rd && (req.addr == `WPM_OFS_DATA_PORT);

  // event flags: power mode write clears all three, a one clears its own bit
  wpm_event_flag u_link_flag (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .set_pulse (evt.link_change),
    .clr_pulse (wr_mode || (wr_status && req.wdata[`WPM_BIT_LINK_FLAG])),
    .flag_q    (link_flag_q)
  );

  wpm_event_flag u_frame_flag (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .set_pulse (evt.wake_frame),
    .clr_pulse (wr_mode || (wr_status && req.wdata[`WPM_BIT_FRAME_FLAG])),
    .flag_q    (frame_flag_q)
  );

  wpm_event_flag u_magic_flag (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .set_pulse (evt.magic_frame),
    .clr_pulse (wr_mode || (wr_status && req.wdata[`WPM_BIT_MAGIC_FLAG])),
    .flag_q    (magic_flag_q)
  );

  // wake source enables
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_en_q  <= 1'b0;
      frame_en_q <= 1'b0;
      magic_en_q <= 1'b0;
    end else if (wr_status) begin
      link_en_q  <= req.wdata[`WPM_BIT_LINK_EN];
      frame_en_q <= req.wdata[`WPM_BIT_FRAME_EN];
      magic_en_q <= req.wdata[`WPM_BIT_MAGIC_EN];
    end
  end

  // light state wakes on enabled remote events only; flags record all of them
  assign light_wake = (mode_q == WPM_MODE_LIGHT) &&
                      ((evt.link_change && link_en_q) ||
                       (evt.wake_frame && frame_en_q) ||
                       (evt.magic_frame && magic_en_q));
  // deep state ignores network events, only the host wake register counts
  assign deep_wake  = (mode_q == WPM_MODE_DEEP) && wr_hostwake;
  assign wake_pulse = light_wake || deep_wake;

  // regulator standby and power mode; wakeup beats a same-cycle mode write for the mode, standby still takes the written bit
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      standby_q <= 1'b0;
      mode_q    <= WPM_MODE_NORMAL;
    end else begin
      if (wr_mode) begin
        standby_q <= req.wdata[`WPM_BIT_REG_STANDBY];
      end
      if (wake_pulse) begin
        mode_q <= WPM_MODE_NORMAL;
      end else if (wr_mode) begin
        // reserved code is the host's fault; stored as written, acts as normal
        mode_q <= wpm_mode_e'(req.wdata[1:0]);
      end
    end
  end

  // reload trigger: stays set until the loader reports completion
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reload_q <= 1'b0;
    end else if (wr_reload && req.wdata[`WPM_BIT_RELOAD]) begin
      reload_q <= 1'b1;
    end else if (reload_done) begin
      reload_q <= 1'b0;
    end
  end

  assign reload_start = wr_reload && req.wdata[`WPM_BIT_RELOAD] && !reload_q;
  assign reload_busy  = reload_q;

  // miscellaneous control
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_en_q  <= 1'b0;
      burst_sel_q <= 1'b0;
      ring_en_q   <= 1'b0;
    end else if (wr_misc) begin
      timer_en_q  <= req.wdata[`WPM_BIT_TIMER_EN];
      burst_sel_q <= req.wdata[`WPM_BIT_BURST_SEL];
      ring_en_q   <= req.wdata[`WPM_BIT_RING_EN];
    end
  end

  // ring ends one page below receive start; only meaningful with ring enabled
  assign ring_last_page = receive_start_page - 8'h01;

  // timer preload bytes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_low_q  <= `WPM_RST_TIMER_BYTE;
      timer_high_q <= `WPM_RST_TIMER_BYTE;
    end else begin
      if (wr_tlow) begin
        timer_low_q <= req.wdata[7:0];
      end
      if (wr_thigh) begin
        timer_high_q <= req.wdata[7:0];
      end
    end
  end

  // data port word and gap segment
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_port_q <= 16'h0000;
      gap_one_q   <= `WPM_RST_GAP_ONE;
    end else begin
      if (data_port_wr) begin
        data_port_q <= req.wdata;
      end
      if (wr_gap) begin
        gap_one_q <= req.wdata[6:0];
      end
    end
  end

  // read images; reserved bits read zero
  always_comb begin
    status_rd = {1'b0, link_flag_q, frame_flag_q, magic_flag_q,
                 1'b0, link_en_q, frame_en_q, magic_en_q};
    mode_rd   = {3'h0, standby_q, 2'h0, mode_q};
    misc_rd   = {5'h00, timer_en_q, burst_sel_q, ring_en_q};
  end

  // read data registered one cycle after the strobe; reload port reads zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
    end else if (req.rd) begin
      if (req.addr == `WPM_OFS_WAKE_STATUS) begin
        rdata_q <= {8'h00, status_rd};
      end else if (req.addr == `WPM_OFS_POWER_MODE) begin
        rdata_q <= {8'h00, mode_rd};
      end else if (req.addr == `WPM_OFS_MISC) begin
        rdata_q <= {8'h00, misc_rd};
      end else if (req.addr == `WPM_OFS_TIMER_LOW) begin
        rdata_q <= {8'h00, timer_low_q};
      end else if (req.addr == `WPM_OFS_TIMER_HIGH) begin
        rdata_q <= {8'h00, timer_high_q};
      end else if (req.addr == `WPM_OFS_DATA_PORT) begin
        rdata_q <= data_port_q;
      end else if (req.addr == `WPM_OFS_GAP_ONE) begin
        rdata_q <= {9'h000, gap_one_q};
      end else begin
        rdata_q <= 16'h0000;
      end
    end
  end

  // control levels out to the controller
  always_comb begin
    ctl.mode                      = mode_q;
    ctl.regulator_standby         = standby_q;
    ctl.gp_timer_enable           = timer_en_q;
    ctl.burst_address_base_select = burst_sel_q;
    ctl.transmit_ring_enable      = ring_en_q;
    ctl.gp_timer_preload          = {timer_high_q, timer_low_q};
    ctl.frame_gap_segment_one     = gap_one_q;
  end

endmodule : wpm_regs
